/* File: pac_pkg.sv */
/*
  pac_pkg: shared constants and types for the pma ability/control register group.
  assumes: included before every pac_* module; all users write pac_pkg::name.
*/
package pac_pkg;

  // management frame layout (clause 45 form)
  localparam logic [5:0]  PRE_ONES      = 6'h20;     // ones needed before a start
  localparam logic [3:0]  HDR_LAST      = 4'hd;      // index of last header bit (14 bits)
  localparam logic [3:0]  DATA_LAST     = 4'hf;      // index of last data bit (16 bits)
  localparam logic [1:0]  ST_CL45       = 2'h0;      // start pattern of extension frames
  localparam logic [1:0]  OP_ADDR       = 2'h0;      // write address register
  localparam logic [1:0]  OP_WRITE      = 2'h1;      // write data
  localparam logic [1:0]  OP_RD_INCR    = 2'h2;      // read data then increment address
  localparam logic [1:0]  OP_READ       = 2'h3;      // read data
  localparam logic [4:0]  DEVAD_PMA     = 5'h01;     // unit address of this block

  // register offsets
  localparam logic [15:0] OFS_SPEED_ABILITY   = 16'h0004;
  localparam logic [15:0] OFS_UNITS_LOW       = 16'h0005;
  localparam logic [15:0] OFS_UNITS_HIGH      = 16'h0006;
  localparam logic [15:0] OFS_MEDIUM_CTRL     = 16'h0007;
  localparam logic [15:0] OFS_PRESENCE_STATUS = 16'h0008;
  localparam logic [15:0] OFS_TX_LANE_DISABLE = 16'h0009;
  localparam logic [15:0] OFS_RX_SIGNAL_DET   = 16'h000a;
  localparam logic [15:0] OFS_EXT_ABILITY     = 16'h000b;

  // speed ability field positions
  localparam int POS_MULTIGIG_LIST_FLAG       = 14;
  localparam int POS_TWO_HALF_GIG_FLAG        = 13;
  localparam int POS_ABILITY_FORTY_HUNDRED    = 10;
  localparam int POS_ABILITY_POINT_MULTIPOINT = 9;
  localparam int POS_ABILITY_FAST_ETH_TX      = 7;
  localparam int POS_ABILITY_BACKPLANE_KX     = 6;
  localparam int POS_ABILITY_HUNDRED_MEG      = 5;
  localparam int POS_ABILITY_ONE_GIG          = 4;
  localparam int POS_ABILITY_PASS_TS          = 2;
  localparam int POS_ABILITY_BASE_TL          = 1;
  localparam int POS_ABILITY_TEN_GIG          = 0;

  // units-in-package field positions
  localparam int POS_NEGOTIATION_UNIT_PRESENT = 7;
  localparam int POS_TC_UNIT_PRESENT          = 6;
  localparam int POS_DTE_EXTENDER_PRESENT     = 5;
  localparam int POS_PHY_EXTENDER_PRESENT     = 4;
  localparam int POS_CODING_SUBLAYER_PRESENT  = 3;
  localparam int POS_WAN_SUBLAYER_PRESENT     = 2;
  localparam int POS_MEDIUM_ATTACH_PRESENT    = 1;
  localparam int POS_LEGACY_REGS_PRESENT      = 0;
  localparam int POS_VENDOR_UNIT_TWO_PRESENT  = 15;
  localparam int POS_VENDOR_UNIT_ONE_PRESENT  = 14;
  localparam int POS_LEGACY_EXTENSION_PRESENT = 13;

  // presence/fault status field positions
  localparam int POS_RESPONDER_CODE           = 14;  // two bits, 15:14
  localparam int POS_TX_FAULT_ABILITY         = 13;
  localparam int POS_RX_FAULT_ABILITY         = 12;
  localparam int POS_TX_FAULT_FLAG            = 11;
  localparam int POS_RX_FAULT_LATCH           = 10;
  localparam int POS_EXTENDED_ABILITY_FLAG    = 9;
  localparam int POS_TX_OFF_ABILITY           = 8;
  localparam int POS_LOOPBACK_ABILITY         = 0;
  localparam logic [1:0]  RESPONDER_CODE_VAL  = 2'h2;   // device answers here

  // extended ability field position
  localparam int POS_MULTIGIG_EXTENDED_FLAG   = 14;

  // transmit-disable and signal-detect positions (lanes at 1..4)
  localparam int POS_GLOBAL_TX_OFF            = 0;
  localparam int POS_LANE1_TX_OFF             = 1;
  localparam int POS_GLOBAL_SIGNAL_SEEN       = 0;
  localparam int POS_LANE1_SIGNAL_SEEN        = 1;

  // medium-type field
  localparam int POS_MEDIUM_TYPE              = 0;   // bits 5:0
  localparam logic [5:0]  MEDIUM_RST          = 6'h09;
  localparam logic [5:0]  MT_CODE_5GT         = 6'h31;
  localparam logic [5:0]  MT_CODE_2P5GT       = 6'h30;
  localparam logic [5:0]  MT_CODE_10T         = 6'h0f;
  localparam logic [5:0]  MT_CODE_100T        = 6'h0e;
  localparam logic [5:0]  MT_CODE_1GT         = 6'h0c;
  localparam logic [5:0]  MT_CODE_10GKR       = 6'h0b;
  localparam logic [5:0]  MT_CODE_10GT        = 6'h09;

  // reset values of writable words, the sampled signal detect and latches
  localparam logic [15:0] MEDIUM_CTRL_RST     = 16'h0009;
  localparam logic [15:0] TX_DISABLE_RST      = 16'h0000;
  localparam logic [4:0]  SIGNAL_DET_RST      = 5'h00;
  localparam logic        RX_FAULT_RST        = 1'b1;

  // constant read words
  localparam logic [15:0] SPEED_ABILITY_VAL = 16'((1 << POS_MULTIGIG_LIST_FLAG) | (1 << POS_ABILITY_FAST_ETH_TX) |
    (1 << POS_ABILITY_HUNDRED_MEG) | (1 << POS_ABILITY_ONE_GIG) | (1 << POS_ABILITY_TEN_GIG));
  localparam logic [15:0] UNITS_LOW_VAL = 16'((1 << POS_NEGOTIATION_UNIT_PRESENT) | (1 << POS_PHY_EXTENDER_PRESENT) |
    (1 << POS_CODING_SUBLAYER_PRESENT) | (1 << POS_MEDIUM_ATTACH_PRESENT) | (1 << POS_LEGACY_REGS_PRESENT));
  localparam logic [15:0] UNITS_HIGH_VAL = 16'((1 << POS_VENDOR_UNIT_TWO_PRESENT) | (1 << POS_VENDOR_UNIT_ONE_PRESENT));
  localparam logic [15:0] STATUS_FIXED_VAL = 16'((int'(RESPONDER_CODE_VAL) << POS_RESPONDER_CODE) |
    (1 << POS_RX_FAULT_ABILITY) | (1 << POS_EXTENDED_ABILITY_FLAG) | (1 << POS_TX_OFF_ABILITY) |
    (1 << POS_LOOPBACK_ABILITY));
  localparam logic [15:0] EXT_ABILITY_VAL = 16'(1 << POS_MULTIGIG_EXTENDED_FLAG);

  // frame receiver states
  typedef enum logic [1:0] {
    PAC_FS_PRE  = 2'b00,
    PAC_FS_HDR  = 2'b01,
    PAC_FS_TA   = 2'b10,
    PAC_FS_DATA = 2'b11
  } pac_frame_state_t;

  // decoded medium type
  typedef enum logic [2:0] {
    PAC_MT_10GT   = 3'b000,
    PAC_MT_5GT    = 3'b001,
    PAC_MT_2P5GT  = 3'b010,
    PAC_MT_1GT    = 3'b011,
    PAC_MT_100T   = 3'b100,
    PAC_MT_10T    = 3'b101,
    PAC_MT_10GKR  = 3'b110,
    PAC_MT_LEGACY = 3'b111
  } pac_medium_t;

endpackage : pac_pkg

/* File: pac_mdc_edge.sv */
/*
  pac_mdc_edge: finds rising edges of the management clock and samples the data pin there.
  assumes: mdc and mdio_in are synchronous to sys_clk and mdc is far slower than sys_clk.
*/
module pac_mdc_edge (
  input  wire logic sys_clk,      // system clock
  input  wire logic sys_rst,      // synchronous reset, high
  input  wire logic mdc,          // management clock level
  input  wire logic mdio_in,      // management data level
  output logic      mdc_rise,     // one-cycle pulse per mdc rising edge
  output logic      mdc_bit       // data sampled at that edge
);

  logic mdc_q_r;                  // previous mdc level
  logic mdc_q_nxt;
  logic rise_r;                   // edge pulse
  logic rise_nxt;
  logic bit_r;                    // captured data bit
  logic bit_nxt;

  // next values: edge compare, data held between edges
  always_comb begin
    mdc_q_nxt = mdc;
    rise_nxt  = mdc & ~mdc_q_r;
    bit_nxt   = (mdc & ~mdc_q_r) ? mdio_in : bit_r;
  end

  // registers only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mdc_q_r <= 1'b0;
      rise_r  <= 1'b0;
      bit_r   <= 1'b1;
    end else begin
      mdc_q_r <= mdc_q_nxt;
      rise_r  <= rise_nxt;
      bit_r   <= bit_nxt;
    end
  end

  assign mdc_rise = rise_r;
  assign mdc_bit  = bit_r;

endmodule : pac_mdc_edge

/* File: pac_fault_latch.sv */
/*
  pac_fault_latch: latched-high receive fault flag, cleared to the live condition by a read.
  assumes: read_clr pulses for one cycle when software's read of the word is captured.
*/
module pac_fault_latch (
  input  wire logic sys_clk,      // system clock
  input  wire logic sys_rst,      // synchronous reset, high
  input  wire logic fault_in,     // live receive-path fault level
  input  wire logic read_clr,     // read of the status word taken
  output logic      fault_latch   // latched flag
);

  logic latch_r;                  // sticky flag, 1 after reset
  logic latch_nxt;

  always_comb begin
    // a fault present during the clearing read keeps the flag set
    if (read_clr) begin
      latch_nxt = fault_in;
    end else begin
      latch_nxt = latch_r | fault_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      latch_r <= pac_pkg::RX_FAULT_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  assign fault_latch = latch_r;

endmodule : pac_fault_latch

/* File: pac_regs.sv */
/*
  pac_regs: pma ability/control register group behind a clause 45 management serial port.
  holds the frame receiver, address register, read mux and the writable control words.
  assumes: mdc/mdio pins are synchronous to sys_clk (40 MHz) and mdc runs well below a quarter of it;
  the mdio wire is resolved outside from mdio_out/mdio_oe with a pull-up.
*/

module pac_regs (
  input  wire logic         sys_clk,         // system clock, 40 MHz
  input  wire logic         sys_rst,         // synchronous reset, high
  input  wire logic [4:0]   port_addr,       // port address this phy answers to
  input  wire logic         mdc,             // management clock from station
  input  wire logic         mdio_in,         // management data pin, input side
  output logic              mdio_out,        // management data pin, output side
  output logic              mdio_oe,         // high while this block drives mdio
  input  wire logic         rx_fault,        // live receive-path fault
  input  wire logic [3:0]   lane_signal,     // live per-lane receive signal detect
  output logic              global_tx_off,   // whole transmitter switched off
  output logic [3:0]        lane_tx_off,     // per-lane transmit off (global folded in)
  output logic [5:0]        medium_type,     // raw medium-type selection
  output pac_pkg::pac_medium_t medium_mode   // decoded medium mode
);

  // edge detector outputs and fault latch signals
  logic                      rise;           // mdc rising edge pulse
  logic                      bit_in;         // bit sampled at that edge
  logic                      fault_latch;    // latched receive fault
  logic                      fault_clr;      // read of status word taken

  // frame receiver state
  pac_pkg::pac_frame_state_t state_r, state_nxt;
  logic [5:0]                pre_cnt_r, pre_cnt_nxt;   // consecutive ones seen
  logic [3:0]                cnt_r, cnt_nxt;           // bit index within phase
  logic [12:0]               hdr_r, hdr_nxt;           // header bits so far
  logic [15:0]               shift_r, shift_nxt;       // data in or out
  logic [1:0]                op_r, op_nxt;             // opcode of this frame
  logic                      out_r, out_nxt;           // driven data level
  logic                      oe_r, oe_nxt;             // drive enable

  // register state
  logic [15:0]               addr_r, addr_nxt;         // clause 45 address register
  logic [15:0]               ctl2_r, ctl2_nxt;         // medium control word
  logic [15:0]               txdis_r, txdis_nxt;       // transmit disable word
  logic [4:0]                sigdet_r, sigdet_nxt;     // sampled signal detect bits
  logic                      gtx_r, gtx_nxt;           // global transmit off output
  logic [3:0]                ltx_r, ltx_nxt;           // lane transmit off outputs
  pac_pkg::pac_medium_t      mode_r, mode_nxt;         // decoded medium output

  // full header once the last bit arrives
  logic [13:0]               hdr_full;
  logic                      hdr_ok;                   // frame is for this unit
  logic                      hdr_rd;                   // frame is a read of either kind
  logic [15:0]               data_full;                // data word once complete

  function automatic pac_pkg::pac_medium_t decode_medium(input logic [5:0] code);
    pac_pkg::pac_medium_t m;
    case (code)
      pac_pkg::MT_CODE_5GT:   m = pac_pkg::PAC_MT_5GT;
      pac_pkg::MT_CODE_2P5GT: m = pac_pkg::PAC_MT_2P5GT;
      pac_pkg::MT_CODE_1GT:   m = pac_pkg::PAC_MT_1GT;
      pac_pkg::MT_CODE_100T:  m = pac_pkg::PAC_MT_100T;
      pac_pkg::MT_CODE_10T:   m = pac_pkg::PAC_MT_10T;
      pac_pkg::MT_CODE_10GKR: m = pac_pkg::PAC_MT_10GKR;
      pac_pkg::MT_CODE_10GT:  m = pac_pkg::PAC_MT_10GT;
      // every other listed code is one of the legacy ten-gig types
      default:                m = pac_pkg::PAC_MT_LEGACY;
    endcase
    return m;
  endfunction : decode_medium

  // read mux; unmapped offsets read zero
  function automatic logic [15:0] read_word(input logic [15:0] a, input logic flt,
                                            input logic [15:0] c2, input logic [15:0] td,
                                            input logic [4:0] sd);
    logic [15:0] w;
    w = 16'h0000;
    case (a)
      pac_pkg::OFS_SPEED_ABILITY:   w = pac_pkg::SPEED_ABILITY_VAL;
      pac_pkg::OFS_UNITS_LOW:       w = pac_pkg::UNITS_LOW_VAL;
      pac_pkg::OFS_UNITS_HIGH:      w = pac_pkg::UNITS_HIGH_VAL;
      pac_pkg::OFS_MEDIUM_CTRL:     w = c2;
      pac_pkg::OFS_PRESENCE_STATUS: w = pac_pkg::STATUS_FIXED_VAL | (16'(flt) << pac_pkg::POS_RX_FAULT_LATCH);
      pac_pkg::OFS_TX_LANE_DISABLE: w = td;
      pac_pkg::OFS_RX_SIGNAL_DET:   w = {11'h000, sd};
      pac_pkg::OFS_EXT_ABILITY:     w = pac_pkg::EXT_ABILITY_VAL;
      default:                      w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  pac_mdc_edge u_edge (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .mdc_rise (rise),
    .mdc_bit  (bit_in)
  );

  pac_fault_latch u_fault (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .fault_in    (rx_fault),
    .read_clr    (fault_clr),
    .fault_latch (fault_latch)
  );

  // header decode: start, port, unit address
  assign hdr_full  = {hdr_r, bit_in};
  // only addressed frames for this unit
  assign hdr_ok    = (hdr_full[13:12] == pac_pkg::ST_CL45) && (hdr_full[9:5] == port_addr) &&
                     (hdr_full[4:0] == pac_pkg::DEVAD_PMA);
  assign hdr_rd    = hdr_full[11];
  assign data_full = {shift_r[14:0], bit_in};

  // the read of status clears the latch at the same edge it is captured
  assign fault_clr = rise && (state_r == pac_pkg::PAC_FS_HDR) && (cnt_r == pac_pkg::HDR_LAST) &&
                     hdr_ok && hdr_rd && (addr_r == pac_pkg::OFS_PRESENCE_STATUS);

  // frame receiver and register updates, all stepped by mdc edges
  always_comb begin
    state_nxt   = state_r;
    pre_cnt_nxt = pre_cnt_r;
    cnt_nxt     = cnt_r;
    hdr_nxt     = hdr_r;
    shift_nxt   = shift_r;
    op_nxt      = op_r;
    out_nxt     = out_r;
    oe_nxt      = oe_r;
    addr_nxt    = addr_r;
    ctl2_nxt    = ctl2_r;
    txdis_nxt   = txdis_r;
    if (rise) begin
      case (state_r)
        pac_pkg::PAC_FS_PRE: begin
          // a zero after 32 ones is the first start bit
          if (bit_in) begin
            if (pre_cnt_r != pac_pkg::PRE_ONES) begin
              pre_cnt_nxt = 6'(pre_cnt_r + 6'h01);
            end
          end else if (pre_cnt_r == pac_pkg::PRE_ONES) begin
            state_nxt   = pac_pkg::PAC_FS_HDR;
            hdr_nxt     = 13'h0000;
            cnt_nxt     = 4'h1;
            pre_cnt_nxt = 6'h00;
          end else begin
            // short preamble: rest of the frame is ignored
            pre_cnt_nxt = 6'h00;
          end
        end
        pac_pkg::PAC_FS_HDR: begin
          hdr_nxt = hdr_full[12:0];
          if (cnt_r == pac_pkg::HDR_LAST) begin
            cnt_nxt = 4'h0;
            op_nxt  = hdr_full[11:10];
            if (hdr_ok) begin
              state_nxt = pac_pkg::PAC_FS_TA;
              if (hdr_rd) begin
                // word is snapshotted here, before the latch clears
                shift_nxt = read_word(addr_r, fault_latch, ctl2_r, txdis_r, sigdet_r);
                if (hdr_full[11:10] == pac_pkg::OP_RD_INCR) begin
                  addr_nxt = 16'(addr_r + 16'h0001);
                end
              end
            end else begin
              // not ours: wait for a fresh preamble
              state_nxt = pac_pkg::PAC_FS_PRE;
            end
          end else begin
            cnt_nxt = 4'(cnt_r + 4'h1);
          end
        end
        pac_pkg::PAC_FS_TA: begin
          if (cnt_r == 4'h0) begin
            cnt_nxt = 4'h1;
            // reads: drive zero in the second turnaround bit
            if (op_r[1]) begin
              oe_nxt  = 1'b1;
              out_nxt = 1'b0;
            end
          end else begin
            cnt_nxt   = 4'h0;
            state_nxt = pac_pkg::PAC_FS_DATA;
            if (op_r[1]) begin
              out_nxt   = shift_r[15];
              shift_nxt = {shift_r[14:0], 1'b0};
            end
          end
        end
        pac_pkg::PAC_FS_DATA: begin
          if (op_r[1]) begin
            if (cnt_r == pac_pkg::DATA_LAST) begin
              // last bit has stood one mdc period: release the pin
              oe_nxt    = 1'b0;
              out_nxt   = 1'b1;
              state_nxt = pac_pkg::PAC_FS_PRE;
            end else begin
              out_nxt   = shift_r[15];
              shift_nxt = {shift_r[14:0], 1'b0};
              cnt_nxt   = 4'(cnt_r + 4'h1);
            end
          end else begin
            shift_nxt = data_full;
            if (cnt_r == pac_pkg::DATA_LAST) begin
              state_nxt = pac_pkg::PAC_FS_PRE;
              if (op_r == pac_pkg::OP_ADDR) begin
                addr_nxt = data_full;
              end else if (op_r == pac_pkg::OP_WRITE) begin
                // whole word stored, reserved bits kept
                if (addr_r == pac_pkg::OFS_MEDIUM_CTRL) begin
                  ctl2_nxt = data_full;
                end
                if (addr_r == pac_pkg::OFS_TX_LANE_DISABLE) begin
                  txdis_nxt = data_full;
                end
              end
            end else begin
              cnt_nxt = 4'(cnt_r + 4'h1);
            end
          end
        end
        default: begin
          state_nxt = pac_pkg::PAC_FS_PRE;
        end
      endcase
    end
  end

  // signal-detect sample from the live lanes; outputs derived from the stored words
  always_comb begin
    sigdet_nxt = {lane_signal, |lane_signal};
    gtx_nxt    = txdis_nxt[pac_pkg::POS_GLOBAL_TX_OFF];
    ltx_nxt    = txdis_nxt[pac_pkg::POS_LANE1_TX_OFF +: 4] | {4{txdis_nxt[pac_pkg::POS_GLOBAL_TX_OFF]}};
    mode_nxt   = decode_medium(ctl2_nxt[pac_pkg::POS_MEDIUM_TYPE +: 6]);
  end

  // all state registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r   <= pac_pkg::PAC_FS_PRE;
      pre_cnt_r <= 6'h00;
      cnt_r     <= 4'h0;
      hdr_r     <= 13'h0000;
      shift_r   <= 16'h0000;
      op_r      <= 2'h0;
      out_r     <= 1'b1;
      oe_r      <= 1'b0;
      addr_r    <= 16'h0000;
      ctl2_r    <= pac_pkg::MEDIUM_CTRL_RST;
      txdis_r   <= pac_pkg::TX_DISABLE_RST;
      sigdet_r  <= pac_pkg::SIGNAL_DET_RST;
      gtx_r     <= 1'b0;
      ltx_r     <= 4'h0;
      mode_r    <= pac_pkg::PAC_MT_10GT;
    end else begin
      state_r   <= state_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      cnt_r     <= cnt_nxt;
      hdr_r     <= hdr_nxt;
      shift_r   <= shift_nxt;
      op_r      <= op_nxt;
      out_r     <= out_nxt;
      oe_r      <= oe_nxt;
      addr_r    <= addr_nxt;
      ctl2_r    <= ctl2_nxt;
      txdis_r   <= txdis_nxt;
      sigdet_r  <= sigdet_nxt;
      gtx_r     <= gtx_nxt;
      ltx_r     <= ltx_nxt;
      mode_r    <= mode_nxt;
    end
  end

  // every output straight from a flip-flop
  assign mdio_out      = out_r;
  assign mdio_oe       = oe_r;
  assign global_tx_off = gtx_r;
  assign lane_tx_off   = ltx_r;
  assign medium_type   = ctl2_r[pac_pkg::POS_MEDIUM_TYPE +: 6];
  assign medium_mode   = mode_r;

endmodule : pac_regs

/* File: pac_checker.sv */
/* pac_checker: port assertions for pac_regs.
   assumes: bound onto pac_regs; one clock domain, reset high. */
module pac_checker (
  input wire logic                 sys_clk,
  input wire logic                 sys_rst,
  input wire logic                 mdio_out,
  input wire logic                 mdio_oe,
  input wire logic                 global_tx_off,
  input wire logic [3:0]           lane_tx_off,
  input wire logic [5:0]           medium_type,
  input wire pac_pkg::pac_medium_t medium_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  rst_values_a: assert property ($fell(sys_rst) |-> medium_type == 6'h09 && lane_tx_off == 4'h0 && !global_tx_off)
    else $error("control reset values wrong");
  rst_pin_a: assert property ($fell(sys_rst) |-> !mdio_oe && mdio_out)
    else $error("data pin not idle after reset");
  global_all_a: assert property (global_tx_off |-> lane_tx_off == 4'hf)
    else $error("global off leaves a lane on");
  ta_low_a: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not driven low");
  oe_hold_a: assert property ($rose(mdio_oe) |-> mdio_oe[*8])
    else $error("read drive dropped early");
  read_quiet_a: assert property (mdio_oe |-> $stable(medium_type) && $stable(global_tx_off))
    else $error("control changed during a read");
  mode_5g_a: assert property (medium_type == 6'h31 && $stable(medium_type) |-> medium_mode == pac_pkg::PAC_MT_5GT)
    else $error("5g code decoded wrong");
  mode_kr_a: assert property (medium_type == 6'h0b && $stable(medium_type) |-> medium_mode == pac_pkg::PAC_MT_10GKR)
    else $error("kr code decoded wrong");
  mode_10gt_a: assert property (medium_type == 6'h09 && $stable(medium_type) |-> medium_mode == pac_pkg::PAC_MT_10GT)
    else $error("default code decoded wrong");
endmodule : pac_checker

bind pac_regs pac_checker i_pac_checker (.sys_clk(sys_clk), .sys_rst(sys_rst), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .global_tx_off(global_tx_off), .lane_tx_off(lane_tx_off), .medium_type(medium_type),
  .medium_mode(medium_mode));

/* File: testbench.sv */
/* testbench: drives pac_regs with mdio frames, checks words and pins.
   assumes: pac_pkg, pac_checker compiled first; mdio pulled up. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk, sys_rst, mdc, drv, ta_s, mdio_out, mdio_oe, rx_fault, global_tx_off;
  logic [4:0]           port_addr;
  logic [3:0]           lane_signal, lane_tx_off;
  logic [5:0]           medium_type;
  logic [15:0]          got;
  pac_pkg::pac_medium_t medium_mode;
  int                   err_total = 0;
  int                   cmp_count = 0;
  // released bench driver idles 1, standing in for the pull-up
  wire logic            mdio_lvl = mdio_oe ? mdio_out : drv;
  pac_regs i_pac_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .port_addr(port_addr), .mdc(mdc),
    .mdio_in(mdio_lvl), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rx_fault(rx_fault), .lane_signal(lane_signal),
    .global_tx_off(global_tx_off), .lane_tx_off(lane_tx_off), .medium_type(medium_type), .medium_mode(medium_mode));
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // one bit: 4 clocks low, sample, 4 high; read data stands until next rise
  task automatic bit_t(input logic b, output logic s);
    @(negedge sys_clk);
    mdc = 0;
    drv = b;
    repeat (4) @(negedge sys_clk);
    s = mdio_lvl;
    mdc = 1;
    repeat (3) @(negedge sys_clk);
  endtask : bit_t
  task automatic frame(input logic [1:0] op, input logic [4:0] dv, input logic [15:0] d, output logic [15:0] r);
    logic [13:0] h;
    logic        s;
    h = {2'b00, op, port_addr, dv};
    for (int i = 0; i < 32; i++) bit_t(1'b1, s);
    for (int i = 13; i >= 0; i--) bit_t(h[i], s);
    bit_t(1'b1, s);
    // reads leave the pin released (pull-up 1), so only the block can pull it low here
    bit_t(op[1], s);
    ta_s = s;
    for (int i = 15; i >= 0; i--) begin
      bit_t(op[1] | d[i], s);
      r[i] = s;
    end
    bit_t(1'b1, s);
  endtask : frame
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [4:0] dv = 5'h01);
    frame(2'b00, dv, a, got);
    frame(2'b01, dv, d, got);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    frame(2'b00, 5'h01, a, got);
    frame(2'b11, 5'h01, 16'h0000, got);
    cmp({15'h0, ta_s}, 16'h0000);
    cmp(got, e);
  endtask : rd
  task automatic t_words;
    rd(16'h0004, 16'h40b1);
    rd(16'h0005, 16'h009b);
    rd(16'h0006, 16'hc000);
    rd(16'h0007, 16'h0009);
    rd(16'h0008, 16'h9701);
    rd(16'h0008, 16'h9301);
    rd(16'h000a, 16'h0000);
    rd(16'h000b, 16'h4000);
    rd(16'h000c, 16'h0000);
    $display("test words done");
  endtask : t_words
  task automatic t_fault;
    rx_fault = 1;
    repeat (4) @(negedge sys_clk);
    rx_fault = 0;
    rd(16'h0008, 16'h9701);
    rd(16'h0008, 16'h9301);
    $display("test fault done");
  endtask : t_fault
  task automatic t_medium;
    logic [5:0] c [7] = '{6'h31, 6'h30, 6'h0c, 6'h0e, 6'h0f, 6'h0b, 6'h07};
    for (int i = 0; i < 7; i++) begin
      wr(16'h0007, {10'h3ff, c[i]});
      cmp({13'h0, medium_mode}, 16'(i + 1));
    end
    rd(16'h0007, 16'hffc7);
    wr(16'h0007, 16'hffc9, 5'h03);
    cmp({10'h0, medium_type}, 16'h0007);
    wr(16'h0007, 16'hffc9);
    cmp({13'h0, medium_mode}, 16'h0000);
    $display("test medium done");
  endtask : t_medium
  task automatic t_lanes;
    lane_signal = 4'h8;
    wr(16'h0009, 16'h0004);
    cmp({11'h0, global_tx_off, lane_tx_off}, 16'h0002);
    wr(16'h0009, 16'h0011);
    cmp({11'h0, global_tx_off, lane_tx_off}, 16'h001f);
    rd(16'h0009, 16'h0011);
    rd(16'h000a, 16'h0011);
    $display("test lanes done");
  endtask : t_lanes
  // mid-run reset: written words and the fault latch go back to their reset values
  task automatic t_reset;
    @(negedge sys_clk);
    sys_rst = 1;
    repeat (6) @(negedge sys_clk);
    sys_rst = 0;
    cmp({10'h0, medium_type}, 16'h0009);
    cmp({13'h0, medium_mode}, 16'h0000);
    cmp({11'h0, global_tx_off, lane_tx_off}, 16'h0000);
    rd(16'h0007, 16'h0009);
    rd(16'h0009, 16'h0000);
    rd(16'h0008, 16'h9701);
    $display("test reset done");
  endtask : t_reset
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    {sys_rst, mdc, drv, rx_fault, lane_signal, port_addr} = {4'b1010, 4'h0, 5'h05};
    repeat (6) @(negedge sys_clk);
    sys_rst = 0;
    t_words;
    t_fault;
    t_medium;
    t_lanes;
    t_reset;
    tally_and_finish;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    tally_and_finish;
  end
endmodule : testbench
